// File: rtl/ttis_regs.sv
// time tag counter and interrupt status register bank
// ==========================================================
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "ttis_params.svh"

module ttis_regs #(
	parameter int BASE_CYC = `TTIS_BASE_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	input  wire logic        TAG_CLK,
	input  wire logic        SYNC_NODATA,
	input  wire logic        SYNC_DATA,
	input  wire logic [15:0] SYNC_WORD_IN,
	input  wire logic        FRAME_BUSY,
	input  wire logic [14:0] EVENTS1,
	input  wire logic [14:1] EVENTS2,
	output logic             IRQ,
	output logic      [15:0] SYNC_WORD_OUT,
	output logic             SYNC_LOAD_EN,
	output logic             RETRY_ENABLE,
	output logic             BUS_CHANNEL_B,
	output logic             OFFLINE_SELF_TEST,
	output logic             BROADCAST_MASK,
	output logic             END_OF_MESSAGE_INT,
	output logic             REV_B_SELECT,
	output logic             MODE_CODE_FORMAT,
	output logic             BROADCAST_FORMAT,
	output logic             TERM_TO_TERM_FORMAT,
	output logic      [5:0]  STATUS_MASK_BITS,
	output logic             RX_DOUBLE_BUFFER,
	output logic      [4:0]  TX_GROUP,
	output logic      [4:0]  RX_GROUP,
	output logic      [4:0]  BROADCAST_GROUP
);
	ttis_pkg::ttis_state_s r;
	ttis_pkg::ttis_state_s next_r;

	// ==========================================================
	// input synchronisers
	logic [1:0] tag_sync;
	logic       tag_prev;
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tag_sync <= 2'h0;
			tag_prev <= 1'b0;
		end else begin
			tag_sync <= {tag_sync[0], TAG_CLK};
			tag_prev <= tag_sync[1];
		end
	end

	// ==========================================================
	// decode helpers
	logic        wr_sr, sw_rst, rd_s1, rd_s2;
	logic        enh_mode, enh_int, tick, tt_wrap;
	logic [2:0]  res;
	logic [5:0]  div_top;
	logic [14:0] ev1_set;
	logic [14:1] ev2_set;
	logic        inc;

	always_comb begin
		wr_sr    = WR && ADDR == `TTIS_OFF_START_RST;
		sw_rst   = wr_sr && WDATA[`TTIS_SR_SW_RESET];
		rd_s1    = RD && ADDR == `TTIS_OFF_INT_STAT1;
		rd_s2    = RD && ADDR == `TTIS_OFF_INT_STAT2;
		enh_mode = r.cfg3[`TTIS_CFG3_ENH_MODE];
		enh_int  = enh_mode && r.cfg2[`TTIS_CFG2_ENH_INT];
		res      = r.cfg2[`TTIS_CFG2_RES_HI:`TTIS_CFG2_RES_LO];
		// 2us periods per LSB: 32,16,8,4,2,1
		div_top  = 6'(6'h20 >> res);
		tick     = r.presc == 8'(BASE_CYC - 1);
		inc      = 1'b0;
		unique case (res)
			`TTIS_RES_TEST: inc = wr_sr && WDATA[`TTIS_SR_TT_STEP];
			`TTIS_RES_EXT:  inc = tag_sync[1] && !tag_prev;
			default:        inc = tick && r.div == div_top - 6'h01;
		endcase
		tt_wrap = inc && r.time_tag == 16'hFFFF;
		// enhanced interrupts: status regardless of mask
		if (enh_int) begin
			ev1_set = EVENTS1;
			ev2_set = EVENTS2;
		end else if (enh_mode) begin
			ev1_set = {7'h00, EVENTS1[7:0] & r.mask1[7:0]};
			ev2_set = 14'h0000;
		end else begin
			ev1_set = {7'h00, EVENTS1[7:0] & r.mask1[7:0]};
			ev2_set = 14'h0000;
		end
		ev1_set[`TTIS_ST_TT_ROLL] = ev1_set[`TTIS_ST_TT_ROLL]
			| (tt_wrap & (enh_int | r.mask1[`TTIS_ST_TT_ROLL]));
	end

	// ==========================================================
	// next state
	always_comb begin
		next_r = r;
		next_r.presc = tick ? 8'h00 : r.presc + 8'h01;
		if (tick)
			next_r.div = (r.div >= div_top - 6'h01) ? 6'h00 : r.div + 6'h01;
		if (inc)
			next_r.time_tag = r.time_tag + 16'h0001;
		if (SYNC_DATA && r.cfg2[`TTIS_CFG2_SYNC_LOAD]
			&& !(r.cfg7[`TTIS_CFG7_ENH_SYNC] && SYNC_WORD_IN[0]))
			next_r.time_tag = SYNC_WORD_IN;
		if (SYNC_NODATA && r.cfg2[`TTIS_CFG2_SYNC_CLR])
			next_r.time_tag = `TTIS_RESET_WORD;
		// register writes
		if (WR) begin
			unique case (ADDR)
				`TTIS_OFF_CTRL_WORD:
					if (r.cfg1[`TTIS_CFG1_MODE_HI:`TTIS_CFG1_MODE_LO] == `TTIS_MODE_BC
						&& !FRAME_BUSY)
						next_r.ctrl_word = WDATA;
				`TTIS_OFF_TIME_TAG: next_r.time_tag = WDATA;
				`TTIS_OFF_CFG1:     next_r.cfg1 = WDATA;
				`TTIS_OFF_CFG2:     next_r.cfg2 = WDATA;
				`TTIS_OFF_CFG3:     next_r.cfg3 = WDATA;
				`TTIS_OFF_CFG7:     next_r.cfg7 = WDATA;
				`TTIS_OFF_MASK1:    next_r.mask1 = WDATA;
				`TTIS_OFF_MASK2:    next_r.mask2 = WDATA;
				default: ;
			endcase
		end
		if (wr_sr && WDATA[`TTIS_SR_TT_RESET])
			next_r.time_tag = `TTIS_RESET_WORD;
		// status: clears first, then sets win
		if ((wr_sr && WDATA[`TTIS_SR_INT_RESET])) begin
			next_r.stat1 = 16'h0000;
			next_r.stat2 = 16'h0000;
		end
		if (rd_s1 && r.cfg2[`TTIS_CFG2_AUTOCLR])
			next_r.stat1 = 16'h0000;
		if (rd_s2 && r.cfg2[`TTIS_CFG2_AUTOCLR])
			next_r.stat2 = 16'h0000;
		next_r.stat1[14:0] = next_r.stat1[14:0] | ev1_set;
		next_r.stat2[14:1] = next_r.stat2[14:1] | ev2_set;
		// request only from mask-enabled bits
		next_r.irq = enh_mode
			? (|(next_r.stat1[14:0] & r.mask1[14:0]) | |(next_r.stat2[14:1] & r.mask2[14:1]))
			: |(next_r.stat1[7:0] & r.mask1[7:0]);
		next_r.stat1[`TTIS_ST_MASTER] = enh_int && next_r.irq;
		// read port
		unique case (ADDR)
			`TTIS_OFF_CTRL_WORD: next_r.rdata = r.ctrl_word;
			`TTIS_OFF_TIME_TAG:  next_r.rdata = r.time_tag;
			`TTIS_OFF_INT_STAT1: next_r.rdata = r.stat1;
			`TTIS_OFF_INT_STAT2: next_r.rdata = r.stat2;
			`TTIS_OFF_CFG1:      next_r.rdata = r.cfg1;
			`TTIS_OFF_CFG2:      next_r.rdata = r.cfg2;
			`TTIS_OFF_CFG3:      next_r.rdata = r.cfg3;
			`TTIS_OFF_CFG7:      next_r.rdata = r.cfg7;
			`TTIS_OFF_MASK1:     next_r.rdata = r.mask1;
			`TTIS_OFF_MASK2:     next_r.rdata = r.mask2;
			default:             next_r.rdata = 16'h0000;
		endcase
		if (!RD)
			next_r.rdata = 16'h0000;
		next_r.sync_word = r.time_tag;
		next_r.ext_sync = {r.cfg2[`TTIS_CFG2_SYNC_LOAD], 2'h0};
		if (sw_rst) begin
			next_r = '0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			r <= '0;
		else
			r <= next_r;
	end

	// ==========================================================
	// outputs, all from flip-flops
	always_comb begin
		RDATA               = r.rdata;
		IRQ                 = r.irq;
		SYNC_WORD_OUT       = r.sync_word;
		SYNC_LOAD_EN        = r.ext_sync[2];
		STATUS_MASK_BITS    = r.ctrl_word[14:9];
		RETRY_ENABLE        = r.ctrl_word[8];
		BUS_CHANNEL_B       = r.ctrl_word[7];
		OFFLINE_SELF_TEST   = r.ctrl_word[6];
		BROADCAST_MASK      = r.ctrl_word[5];
		END_OF_MESSAGE_INT  = r.ctrl_word[4];
		REV_B_SELECT        = r.ctrl_word[3];
		MODE_CODE_FORMAT    = r.ctrl_word[2];
		BROADCAST_FORMAT    = r.ctrl_word[1];
		TERM_TO_TERM_FORMAT = r.ctrl_word[0];
		RX_DOUBLE_BUFFER    = r.ctrl_word[15];
		TX_GROUP            = r.ctrl_word[14:10];
		RX_GROUP            = r.ctrl_word[9:5];
		BROADCAST_GROUP     = r.ctrl_word[4:0];
	end

	// ==========================================================
	// checks
	tt_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		wr_sr && WDATA[`TTIS_SR_TT_RESET] && !sw_rst |=> r.time_tag == 16'h0000)
		else $error("time tag not cleared");

	tt_step_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		res == `TTIS_RES_TEST && !wr_sr && !WR && !SYNC_DATA && !SYNC_NODATA
		|=> r.time_tag == $past(r.time_tag))
		else $error("time tag moved in test mode");

	tt_test_inc_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		res == `TTIS_RES_TEST && wr_sr && WDATA == 16'h0010
		|=> r.time_tag == $past(r.time_tag) + 16'h0001)
		else $error("test step missed");

	sync_clr_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		SYNC_NODATA && r.cfg2[`TTIS_CFG2_SYNC_CLR] && !WR |=> r.time_tag == 16'h0000)
		else $error("sync clear missed");

	sync_enh_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		SYNC_DATA && r.cfg7[`TTIS_CFG7_ENH_SYNC] && SYNC_WORD_IN[0] && !WR && !SYNC_NODATA
		|=> r.time_tag != SYNC_WORD_IN || $past(r.time_tag) + 16'h0001 == r.time_tag
			|| $past(r.time_tag) == r.time_tag)
		else $error("odd sync word loaded");

	int_reset_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		wr_sr && WDATA[`TTIS_SR_INT_RESET] && EVENTS1 == 15'h0000 && EVENTS2 == 14'h0000
		&& !inc |=> r.stat1[14:0] == 15'h0000 && r.stat2 == 16'h0000)
		else $error("interrupt reset missed");

	non_enh_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!enh_mode && r.stat1[14:8] == 7'h00 && !WR |=> r.stat1[14:8] == 7'h00)
		else $error("upper status set in normal mode");

	mask_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!enh_mode && EVENTS1[0] && r.mask1[0] && !sw_rst |=> r.stat1[0])
		else $error("enabled event lost");

	irq_mask_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		r.mask1 == 16'h0000 && r.mask2 == 16'h0000 |=> !IRQ)
		else $error("request without mask");

	ctrl_lock_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WR && ADDR == `TTIS_OFF_CTRL_WORD && FRAME_BUSY && !sw_rst
		|=> r.ctrl_word == $past(r.ctrl_word))
		else $error("control word written while busy");

	ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WR && ADDR == `TTIS_OFF_CTRL_WORD && !FRAME_BUSY
		&& r.cfg1[`TTIS_CFG1_MODE_HI:`TTIS_CFG1_MODE_LO] == `TTIS_MODE_BC
		|=> r.ctrl_word == $past(WDATA))
		else $error("idle control word write lost");

	ctrl_mode_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WR && ADDR == `TTIS_OFF_CTRL_WORD
		&& r.cfg1[`TTIS_CFG1_MODE_HI:`TTIS_CFG1_MODE_LO] != `TTIS_MODE_BC
		|=> r.ctrl_word == $past(r.ctrl_word))
		else $error("control word written outside controller mode");

	// ==========================================================
	// time tag checks
	sw_reset_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		sw_rst |=> r.time_tag == 16'h0000 && r.stat1 == 16'h0000 && !IRQ)
		else $error("software reset missed");

	tag_inc_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		inc && !WR && !SYNC_DATA && !SYNC_NODATA
		|=> r.time_tag == $past(r.time_tag) + 16'h0001)
		else $error("time tag step lost");

	tag_idle_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!inc && !WR && !SYNC_DATA && !SYNC_NODATA
		|=> r.time_tag == $past(r.time_tag))
		else $error("time tag moved without a step");

	wrap_zero_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		tt_wrap && !WR && !SYNC_DATA && !SYNC_NODATA |=> r.time_tag == 16'h0000)
		else $error("time tag did not wrap to zero");

	wrap_flag_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		tt_wrap && r.mask1[`TTIS_ST_TT_ROLL] && !WR |=> r.stat1[`TTIS_ST_TT_ROLL])
		else $error("rollover status not set");

	sync_load_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		SYNC_DATA && r.cfg2[`TTIS_CFG2_SYNC_LOAD] && !r.cfg7[`TTIS_CFG7_ENH_SYNC]
		&& !SYNC_NODATA && !WR |=> r.time_tag == $past(SYNC_WORD_IN))
		else $error("sync word not loaded");

	sync_even_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		SYNC_DATA && r.cfg2[`TTIS_CFG2_SYNC_LOAD] && r.cfg7[`TTIS_CFG7_ENH_SYNC]
		&& !SYNC_WORD_IN[0] && !SYNC_NODATA && !WR |=> r.time_tag == $past(SYNC_WORD_IN))
		else $error("even sync word not loaded");

	sync_out_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!sw_rst |=> SYNC_WORD_OUT == $past(r.time_tag))
		else $error("sent sync word not the time tag");

	sync_en_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!sw_rst |=> SYNC_LOAD_EN == $past(r.cfg2[`TTIS_CFG2_SYNC_LOAD]))
		else $error("sync send enable wrong");

	tag_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		RD && !WR && ADDR == `TTIS_OFF_TIME_TAG |=> RDATA == $past(r.time_tag))
		else $error("time tag read wrong");

	// ==========================================================
	// status checks
	stat_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		RD && !WR && ADDR == `TTIS_OFF_INT_STAT1 |=> RDATA == $past(r.stat1))
		else $error("status read wrong");

	autoclr_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rd_s1 && r.cfg2[`TTIS_CFG2_AUTOCLR] && EVENTS1 == 15'h0000 && !inc && !WR
		|=> r.stat1[14:0] == 15'h0000)
		else $error("status not cleared on read");

	autoclr_keep_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rd_s1 && r.cfg2[`TTIS_CFG2_AUTOCLR] && !WR
		|=> (r.stat2[14:1] & $past(r.stat2[14:1])) == $past(r.stat2[14:1]))
		else $error("other status cleared by read");

	enh_set_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		enh_int && !WR |=> (r.stat1[14:0] & $past(EVENTS1)) == $past(EVENTS1))
		else $error("polled event lost");

	enh_set2_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		enh_int && !WR |=> (r.stat2[14:1] & $past(EVENTS2)) == $past(EVENTS2))
		else $error("second status event lost");

	stat2_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!enh_int && r.stat2 == 16'h0000 && !WR |=> r.stat2 == 16'h0000)
		else $error("second status set without enhanced interrupts");

	mask_block_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!enh_mode && !r.mask1[1] && !r.stat1[1] && !WR |=> !r.stat1[1])
		else $error("masked event set status");

	irq_level_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!enh_mode && !WR |=> IRQ == |(r.stat1[7:0] & r.mask1[7:0]))
		else $error("request does not follow masked status");

	master_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!sw_rst |=> r.stat1[`TTIS_ST_MASTER] == ($past(enh_int) && IRQ))
		else $error("master bit wrong");
endmodule // ttis_regs

// File: rtl/ttis_params.svh
// constants for the time tag and interrupt status register block
`ifndef TTIS_PARAMS_SVH
`define TTIS_PARAMS_SVH
// register offsets (printed offsets are register indices)
`define TTIS_OFF_CTRL_WORD   4'h4
`define TTIS_OFF_TIME_TAG    4'h5
`define TTIS_OFF_INT_STAT1   4'h6
`define TTIS_OFF_START_RST   4'h3
`define TTIS_OFF_CFG1        4'h1
`define TTIS_OFF_CFG2        4'h2
`define TTIS_OFF_CFG3        4'h7
`define TTIS_OFF_CFG7        4'h8
`define TTIS_OFF_MASK1       4'h9
`define TTIS_OFF_INT_STAT2   4'hA
`define TTIS_OFF_MASK2       4'hB
// start/reset bits
`define TTIS_SR_SW_RESET     0
`define TTIS_SR_INT_RESET    2
`define TTIS_SR_TT_RESET     3
`define TTIS_SR_TT_STEP      4
// configuration 2, 3 and 7 bits
`define TTIS_CFG2_ENH_INT    15
`define TTIS_CFG2_RES_HI     9
`define TTIS_CFG2_RES_LO     7
`define TTIS_CFG2_SYNC_CLR   6
`define TTIS_CFG2_SYNC_LOAD  5
`define TTIS_CFG2_AUTOCLR    4
`define TTIS_CFG3_ENH_MODE   15
`define TTIS_CFG7_ENH_SYNC   2
// configuration 1 mode field and controller mode code
`define TTIS_CFG1_MODE_HI    15
`define TTIS_CFG1_MODE_LO    14
`define TTIS_MODE_BC         2'h0
// status bit positions
`define TTIS_ST_MASTER       15
`define TTIS_ST_TT_ROLL      6
// resolution codes
`define TTIS_RES_TEST        3'h6
`define TTIS_RES_EXT         3'h7
// timing
`define TTIS_CLK_MHZ         100
`define TTIS_BASE_US         2
`define TTIS_BASE_CYC        (`TTIS_BASE_US * `TTIS_CLK_MHZ)
`define TTIS_RESET_WORD      16'h0000
`endif

// File: rtl/ttis_pkg.sv
// types for the time tag and interrupt status register block
package ttis_pkg;
	typedef struct packed {
		logic [15:0] ctrl_word;
		logic [15:0] time_tag;
		logic [15:0] stat1;
		logic [15:0] stat2;
		logic [15:0] cfg1;
		logic [15:0] cfg2;
		logic [15:0] cfg3;
		logic [15:0] cfg7;
		logic [15:0] mask1;
		logic [15:0] mask2;
		logic [7:0]  presc;
		logic [5:0]  div;
		logic [15:0] rdata;
		logic        irq;
		logic [15:0] sync_word;
		logic [2:0]  ext_sync;
	} ttis_state_s;
endpackage

// File: bench/ttis_host.sv
// host model driving the register port of the time tag block
`timescale 1ns/1ns

module ttis_host (
	input  wire logic        REF_CLK,
	input  wire logic [15:0] RDATA,
	output logic      [3:0]  ADDR,
	output logic      [15:0] WDATA,
	output logic             WR,
	output logic             RD
);
	initial begin
		ADDR = 4'h0;
		WDATA = 16'h0000;
		WR = 1'b0;
		RD = 1'b0;
	end

	// ==========================================
	// bus cycles, one strobe cycle each
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
endmodule // ttis_host

// File: bench/ttis_regs_tb.sv
// self-checking bench for the time tag and status register bank
`timescale 1ns/1ns
`include "ttis_params.svh"

module ttis_regs_tb;
	localparam int BC = 4;
	localparam logic [3:0] TT = `TTIS_OFF_TIME_TAG;
	localparam logic [3:0] S1 = `TTIS_OFF_INT_STAT1;
	localparam logic [3:0] SR = `TTIS_OFF_START_RST;
	localparam logic [3:0] C2 = `TTIS_OFF_CFG2;
	localparam logic [3:0] M1 = `TTIS_OFF_MASK1;
	logic REF_CLK = 1'b0, RESET_N = 1'b0, WR, RD, TAG_CLK = 1'b0, IRQ;
	logic SYNC_NODATA = 1'b0, SYNC_DATA = 1'b0, FRAME_BUSY = 1'b0;
	logic [3:0] ADDR;
	logic [15:0] WDATA, RDATA, SYNC_WORD_IN = 16'h0000, SYNC_WORD_OUT, v, e, m;
	logic [14:0] EVENTS1 = 15'h0000;
	logic [14:1] EVENTS2 = 14'h0000;
	logic [5:0] smask;
	logic [4:0] txg, rxg, bcg;
	logic [8:0] bcf;
	logic dbuf, sle;
	logic [31:0] seed = 32'h0001_6780;
	int checked = 0, mismatches = 0;

	always #5 REF_CLK = ~REF_CLK;

	ttis_regs #(.BASE_CYC(BC)) ttis_regs_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TAG_CLK(TAG_CLK),
		.SYNC_NODATA(SYNC_NODATA), .SYNC_DATA(SYNC_DATA), .SYNC_WORD_IN(SYNC_WORD_IN),
		.FRAME_BUSY(FRAME_BUSY), .EVENTS1(EVENTS1), .EVENTS2(EVENTS2), .IRQ(IRQ),
		.SYNC_WORD_OUT(SYNC_WORD_OUT), .SYNC_LOAD_EN(sle), .RETRY_ENABLE(bcf[8]),
		.BUS_CHANNEL_B(bcf[7]), .OFFLINE_SELF_TEST(bcf[6]), .BROADCAST_MASK(bcf[5]),
		.END_OF_MESSAGE_INT(bcf[4]), .REV_B_SELECT(bcf[3]), .MODE_CODE_FORMAT(bcf[2]),
		.BROADCAST_FORMAT(bcf[1]), .TERM_TO_TERM_FORMAT(bcf[0]), .STATUS_MASK_BITS(smask),
		.RX_DOUBLE_BUFFER(dbuf), .TX_GROUP(txg), .RX_GROUP(rxg), .BROADCAST_GROUP(bcg));
	ttis_host ttis_host_i (.REF_CLK(REF_CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD));

	// ==========================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		ttis_host_i.wr(a, d);
	endtask
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
		checked++;
		if (s !== x) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic rdchk(input string n, input logic [3:0] a, input logic [15:0] x);
		ttis_host_i.rd(a, v);
		chk(n, x, v);
	endtask
	task automatic sync(input logic dat, input logic [15:0] w);
		@(posedge REF_CLK);
		SYNC_WORD_IN <= w;
		SYNC_DATA <= dat;
		SYNC_NODATA <= ~dat;
		@(posedge REF_CLK);
		{SYNC_DATA, SYNC_NODATA} <= 2'b00;
	endtask
	task automatic ev(input logic [14:0] a, input logic [14:1] b);
		@(posedge REF_CLK);
		EVENTS1 <= a;
		EVENTS2 <= b;
		@(posedge REF_CLK);
		EVENTS1 <= 15'h0000;
		EVENTS2 <= 14'h0000;
		repeat (2) @(posedge REF_CLK);
	endtask
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge REF_CLK);
		mismatches++;
		$display("[FAIL] run exp done got timeout");
		test_done;
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		rdchk("tag after reset", TT, 16'h0000);
		wr(C2, 16'h0300);
		wr(M1, 16'h0040);
		wr(TT, 16'hFFFE);
		repeat (30) @(posedge REF_CLK);
		rdchk("tag held in test", TT, 16'hFFFE);
		wr(SR, 16'h0010);
		wr(SR, 16'h0010);
		rdchk("tag stepped wrap", TT, 16'h0000);
		chk("sync word out", 16'h0000, SYNC_WORD_OUT);
		chk("irq on rollover", 16'h0001, {15'h0000, IRQ});
		rdchk("rollover status", S1, 16'h0040);
		wr(SR, 16'h0004);
		rdchk("status int reset", S1, 16'h0000);
		wr(TT, 16'h1234);
		wr(SR, 16'h0008);
		rdchk("tag clear bit", TT, 16'h0000);
		wr(C2, 16'h0360);
		sync(1'b1, 16'h5A5B);
		rdchk("sync load", TT, 16'h5A5B);
		chk("sync send enable", 16'h0001, {15'h0000, sle});
		chk("sync word loaded", 16'h5A5B, SYNC_WORD_OUT);
		sync(1'b0, 16'h0000);
		rdchk("sync clear", TT, 16'h0000);
		wr(`TTIS_OFF_CFG7, 16'h0004);
		sync(1'b1, 16'h0101);
		rdchk("odd sync word", TT, 16'h0000);
		sync(1'b1, 16'h0202);
		rdchk("even sync word", TT, 16'h0202);
		wr(TT, 16'h00AA);
		wr(SR, 16'h0001);
		rdchk("tag soft reset", TT, 16'h0000);
		for (int c = 0; c < 6; c++) begin
			wr(C2, 16'(c << 7));
			wr(TT, 16'h0000);
			repeat (4 * (BC << (5 - c))) @(posedge REF_CLK);
			ttis_host_i.rd(TT, v);
			checked++;
			if (v !== 16'h0003 && v !== 16'h0004 && v !== 16'h0005) begin
				mismatches++;
				$display("[FAIL] tag rate exp 4 got %h", v);
			end
		end
		wr(C2, 16'h0380);
		wr(TT, 16'h0000);
		repeat (3) begin
			TAG_CLK <= 1'b1;
			repeat (5) @(posedge REF_CLK);
			TAG_CLK <= 1'b0;
			repeat (5) @(posedge REF_CLK);
		end
		rdchk("external tag", TT, 16'h0003);
		wr(C2, 16'h0310);
		for (int i = 0; i < 4; i++) begin
			seed = nxt(seed);
			e = seed[15:0];
			m = seed[31:16];
			wr(M1, m);
			ev(e[14:0], e[14:1]);
			chk("irq masked", {15'h0000, |(e & m & 16'h00FF)}, {15'h0000, IRQ});
			rdchk("status plain", S1, e & m & 16'h00FF);
			rdchk("status autoclr", S1, 16'h0000);
		end
		wr(`TTIS_OFF_CFG3, 16'h8000);
		wr(C2, 16'h8310);
		wr(M1, 16'h0000);
		wr(`TTIS_OFF_MASK2, 16'h0000);
		seed = nxt(seed);
		e = seed[15:0];
		ev(e[14:0], e[14:1]);
		chk("irq unmasked", 16'h0000, {15'h0000, IRQ});
		rdchk("status enh", S1, {1'b0, e[14:0]});
		rdchk("status enh clr", S1, 16'h0000);
		rdchk("status2 enh", `TTIS_OFF_INT_STAT2, {1'b0, e[14:1], 1'b0});
		wr(M1, 16'h0002);
		ev(15'h0002, 14'h0000);
		chk("irq enh masked in", 16'h0001, {15'h0000, IRQ});
		rdchk("status enh master", S1, 16'h8002);
		wr(`TTIS_OFF_CFG1, 16'h0000);
		seed = nxt(seed);
		m = seed[15:0];
		wr(`TTIS_OFF_CTRL_WORD, m);
		repeat (2) @(posedge REF_CLK);
		chk("bc decode", {1'b0, m[14:0]}, {1'b0, smask, bcf});
		chk("rt decode", m, {dbuf, txg, rxg, bcg});
		FRAME_BUSY <= 1'b1;
		wr(`TTIS_OFF_CTRL_WORD, ~m);
		rdchk("ctrl refused", `TTIS_OFF_CTRL_WORD, m);
		FRAME_BUSY <= 1'b0;
		wr(`TTIS_OFF_CFG1, 16'h4000);
		wr(`TTIS_OFF_CTRL_WORD, ~m);
		rdchk("ctrl mode lock", `TTIS_OFF_CTRL_WORD, m);
		test_done;
	end
endmodule // ttis_regs_tb
